// file: include/rxpts_pkg.sv
// shared constants and types of the receive polling timing sequencer
package rxpts_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the avalon slave
  localparam logic [3:0] RXPTS_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] RXPTS_SLEEP_ADDR  = 4'h4;
  localparam logic [3:0] RXPTS_LIMIT_ADDR  = 4'h8;
  localparam logic [3:0] RXPTS_STATUS_ADDR = 4'hc;

  // control word field positions
  localparam int RXPTS_CTRL_EN_BIT   = 0;
  localparam int RXPTS_CTRL_LIM_BIT  = 1;
  localparam int RXPTS_CTRL_BR_LSB   = 2;
  localparam int RXPTS_CTRL_BCHK_LSB = 4;
  // sleep word field positions
  localparam int RXPTS_SLEEP_LSB     = 0;
  localparam int RXPTS_SLEEP_W       = 5;
  localparam int RXPTS_SLEEP_MULTIPLIER_LSB    = 8;
  localparam int RXPTS_SLEEP_MULTIPLIER_W      = 8;
  // limit word field positions
  localparam int RXPTS_LIMMIN_LSB    = 0;
  localparam int RXPTS_LIMMAX_LSB    = 8;
  localparam int RXPTS_LIM_W         = 8;
  // status word, sticky failure flag position
  localparam int RXPTS_STAT_FAIL_BIT = 16;

  // reset values
  localparam logic [31:0] RXPTS_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] RXPTS_SLEEP_RESET = 32'h0000_0101;
  localparam logic [31:0] RXPTS_LIMIT_RESET = 32'h0000_0f05;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: crystal periods per basic clock, figures in basic clock periods
  localparam int XTAL_PER_BASIC      = 16;
  localparam int XTAL_PER_HALF_BASIC = XTAL_PER_BASIC / 2;
  localparam int SLEEP_UNIT_BASIC    = 1024;
  localparam int SLEEP_UNIT_SHIFT    = $clog2(SLEEP_UNIT_BASIC) + 1;  // in half periods
  // pll start-up of 798.5 basic periods held as half periods
  localparam logic [23:0] PLL_STARTUP_HALF = 24'h00063d;            // 1597 halves
  // signal processing start-up per bit-rate range: 930, 546, 354, 258 basic
  localparam logic [23:0] SIGP_STARTUP_HALF [4] = '{24'h000744, 24'h000444,
                                                   24'h0002c4, 24'h000204};
  // extended clock multiple with limit select low; doubled with it high
  localparam logic [4:0]  EXT_MULT_BASE_LO = 5'h08;
  localparam logic [4:0]  EXT_MULT_BASE_HI = 5'h10;
  // bit-check counts selectable by software: 0, 3, 6, 9 signal periods
  localparam logic [4:0]  BCHK_PERIODS [4] = '{5'h00, 5'h03, 5'h06, 5'h09};

  ////////////////////////////////////////////////////////////////////////////////
  // polling states, gray coded along the usual path
  typedef enum logic [2:0] {
    RXPTS_IDLE   = 3'h0,
    RXPTS_SLEEP  = 3'h1,
    RXPTS_PLL    = 3'h3,
    RXPTS_SIGP   = 3'h2,
    RXPTS_BCHK   = 3'h6,
    RXPTS_RECV   = 3'h7
  } rxpts_state_type;

  // control settings carried together
  typedef struct packed {
    logic       enable;
    logic       clock_limit_select;
    logic [1:0] bit_rate_range;
    logic [1:0] bit_check_select;
  } rxpts_cfg_type;

endpackage

// file: hdl/rxpts_tick_div.sv
`timescale 1ns/100ps
`default_nettype none
// pulse generator: one tick every div enabled cycles
module rxpts_tick_div #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // division control
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  // tick out
  output logic              tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // a divisor of zero behaves like one so the tick never stops
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (en) begin
      if (div == '0 || count >= div - W'(1)) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule
`default_nettype wire

// file: hdl/rxpts_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - basic clock is sixteen crystal periods
// - extended clock multiple from range and limit
// - pll 798.5, then range dependent start-up
// - no signal ends bit-check near one period
// - valid signal passes after N periods
// - edge interval checked against two limits
module rxpts_top
  import rxpts_pkg::*;
(
  // clock and reset; CLOCK is the crystal clock
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // demodulated manchester data pin
  input  wire logic        RX_DATA,
  // receive path controls
  output logic             PLL_ENABLE,
  output logic             SIG_PROC_ENABLE,
  output logic             DATA_VALID,
  output logic             EXT_CLOCK_TICK
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0]     ctrl_reg;
  logic [31:0]     sleep_reg;
  logic [31:0]     limit_reg;
  logic [31:0]     next_ctrl_reg;
  logic [31:0]     next_sleep_reg;
  logic [31:0]     next_limit_reg;
  logic            fail_seen;
  logic            next_fail_seen;
  logic            ack;
  logic            next_ack;
  logic [31:0]     next_readdata;
  logic            wr_take;
  rxpts_cfg_type   cfg;
  logic            half_tick;
  logic            basic_tick;
  logic            ext_tick;
  logic [4:0]      ext_mult;
  logic            rx_meta;
  logic            rx_sync;
  logic            rx_prev;
  logic            rx_edge;
  rxpts_state_type state;
  rxpts_state_type next_state;
  logic [23:0]     timer;
  logic [23:0]     next_timer;
  logic [23:0]     sleep_half;
  logic [12:0]     sleep_prod;
  logic [7:0]      ivl;
  logic [7:0]      next_ivl;
  logic            seen_edge;
  logic            next_seen_edge;
  logic [4:0]      good;
  logic [4:0]      next_good;
  logic [4:0]      good_need;
  logic [7:0]      lim_min;
  logic [7:0]      lim_max;
  logic            chk_fail;
  logic            next_pll_enable;
  logic            next_sig_proc_enable;
  logic            next_data_valid;
  logic            next_ext_clock_tick;

  assign cfg.enable             = ctrl_reg[RXPTS_CTRL_EN_BIT];
  assign cfg.clock_limit_select = ctrl_reg[RXPTS_CTRL_LIM_BIT];
  assign cfg.bit_rate_range     = ctrl_reg[RXPTS_CTRL_BR_LSB +: 2];
  assign cfg.bit_check_select   = ctrl_reg[RXPTS_CTRL_BCHK_LSB +: 2];
  assign lim_min = limit_reg[RXPTS_LIMMIN_LSB +: RXPTS_LIM_W];
  assign lim_max = limit_reg[RXPTS_LIMMAX_LSB +: RXPTS_LIM_W];

  ////////////////////////////////////////////////////////////////////////////////
  // clock dividers: half and full basic periods from the crystal clock
  rxpts_tick_div #(.W(5)) u_half_div (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .en    (1'b1),
    .div   (5'(XTAL_PER_HALF_BASIC)),
    .tick  (half_tick)
  );

  // both dividers start together, so every basic tick is also a half tick
  rxpts_tick_div #(.W(5)) u_basic_div (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .en    (1'b1),
    .div   (5'(XTAL_PER_BASIC)),
    .tick  (basic_tick)
  );

  // extended clock multiple halves per range step, doubled by the limit bit
  assign ext_mult = (cfg.clock_limit_select ? EXT_MULT_BASE_HI : EXT_MULT_BASE_LO)
                    >> cfg.bit_rate_range;

  rxpts_tick_div #(.W(5)) u_ext_div (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .en    (basic_tick),
    .div   (ext_mult),
    .tick  (ext_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // receive data pin: two-flop synchroniser, then a third flop for edges
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_prev <= 1'b0;
    end else begin
      rx_meta <= RX_DATA;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_edge = rx_sync ^ rx_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then waitrequest low for a single edge
  assign wr_take = AVS_WRITE && ack;

  always_comb begin
    next_ack      = (AVS_READ || AVS_WRITE) && !ack;
    next_readdata = AVS_READDATA;
    if (AVS_READ && !ack) begin
      if (AVS_ADDRESS == RXPTS_CTRL_ADDR) begin
        next_readdata = ctrl_reg;
      end else if (AVS_ADDRESS == RXPTS_SLEEP_ADDR) begin
        next_readdata = sleep_reg;
      end else if (AVS_ADDRESS == RXPTS_LIMIT_ADDR) begin
        next_readdata = limit_reg;
      end else if (AVS_ADDRESS == RXPTS_STATUS_ADDR) begin
        next_readdata = '0;
        next_readdata[2:0]  = state;
        next_readdata[3]    = DATA_VALID;
        next_readdata[8:4]  = good;
        next_readdata[15:9] = ivl[6:0];
        next_readdata[RXPTS_STAT_FAIL_BIT] = fail_seen;
      end else begin
        next_readdata = '0;  // unmapped reads as zero
      end
    end
  end

  // register writes land at the edge where waitrequest is seen low
  always_comb begin
    next_ctrl_reg  = ctrl_reg;
    next_sleep_reg = sleep_reg;
    next_limit_reg = limit_reg;
    next_fail_seen = fail_seen;
    if (wr_take) begin
      if (AVS_ADDRESS == RXPTS_CTRL_ADDR) begin
        next_ctrl_reg = {26'h0, AVS_WRITEDATA[5:0]};
      end else if (AVS_ADDRESS == RXPTS_SLEEP_ADDR) begin
        next_sleep_reg = {16'h0, AVS_WRITEDATA[15:8], 3'h0, AVS_WRITEDATA[4:0]};
      end else if (AVS_ADDRESS == RXPTS_LIMIT_ADDR) begin
        next_limit_reg = {16'h0, AVS_WRITEDATA[15:0]};
      end else if (AVS_ADDRESS == RXPTS_STATUS_ADDR &&
                   AVS_WRITEDATA[RXPTS_STAT_FAIL_BIT]) begin
        next_fail_seen = 1'b0;  // write one to clear
      end
    end
    // a failure in the clearing cycle still sets the flag
    if (chk_fail) begin
      next_fail_seen = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg        <= RXPTS_CTRL_RESET;
      sleep_reg       <= RXPTS_SLEEP_RESET;
      limit_reg       <= RXPTS_LIMIT_RESET;
      fail_seen       <= 1'b0;
      ack             <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= '0;
    end else begin
      ctrl_reg        <= next_ctrl_reg;
      sleep_reg       <= next_sleep_reg;
      limit_reg       <= next_limit_reg;
      fail_seen       <= next_fail_seen;
      ack             <= next_ack;
      AVS_WAITREQUEST <= !next_ack;
      AVS_READDATA    <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sleep length in half basic periods: sleep x multiplier x 1024 x 2
  // product kept at full width before the shift, else long sleeps would wrap
  assign sleep_prod = 13'(sleep_reg[RXPTS_SLEEP_LSB +: RXPTS_SLEEP_W]) *
                      13'(sleep_reg[RXPTS_SLEEP_MULTIPLIER_LSB +: RXPTS_SLEEP_MULTIPLIER_W]);
  assign sleep_half = {sleep_prod, SLEEP_UNIT_SHIFT'(0)};
  // two edge intervals per manchester period
  assign good_need  = BCHK_PERIODS[cfg.bit_check_select] << 1;

  // bit-check fails on a short or long interval; a silent input times out
  // after lim_max, about one signal period, so polling resumes fast
  always_comb begin
    chk_fail = 1'b0;
    if (state == RXPTS_BCHK && good_need != 5'h00) begin
      if (rx_edge && seen_edge && (ivl < lim_min || ivl > lim_max)) begin
        chk_fail = 1'b1;
      end else if (!rx_edge && ivl > lim_max) begin
        chk_fail = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // polling sequencer
  always_comb begin
    next_state     = state;
    next_timer     = timer;
    next_ivl       = ivl;
    next_seen_edge = seen_edge;
    next_good      = good;
    if (half_tick) begin
      next_timer = timer + 24'h000001;
    end
    case (state)
      RXPTS_IDLE: begin
        next_timer = '0;
        if (cfg.enable) begin
          next_state = RXPTS_SLEEP;
        end
      end
      RXPTS_SLEEP: begin
        if (timer >= sleep_half) begin
          next_state = RXPTS_PLL;
          next_timer = '0;
        end
      end
      RXPTS_PLL: begin
        if (timer >= PLL_STARTUP_HALF) begin
          next_state = RXPTS_SIGP;
          next_timer = '0;
        end
      end
      RXPTS_SIGP: begin
        if (timer >= SIGP_STARTUP_HALF[cfg.bit_rate_range]) begin
          next_state     = RXPTS_BCHK;
          next_ivl       = '0;
          next_seen_edge = 1'b0;
          next_good      = '0;
        end
      end
      RXPTS_BCHK: begin
        if (ext_tick && ivl != 8'hff) begin
          next_ivl = ivl + 8'h01;
        end
        if (good == good_need) begin
          next_state = RXPTS_RECV;
        end else if (chk_fail) begin
          next_state = RXPTS_SLEEP;
          next_timer = '0;
        end else if (rx_edge) begin
          next_ivl       = '0;
          next_seen_edge = 1'b1;
          if (seen_edge) begin
            next_good = good + 5'h01;
          end
        end
      end
      RXPTS_RECV: begin
        next_timer = '0;
      end
      default: begin
        next_state = RXPTS_IDLE;
      end
    endcase
    // dropping the enable stops polling from any state
    if (!cfg.enable) begin
      next_state = RXPTS_IDLE;
      next_timer = '0;
    end
  end

  // state outputs follow the next state and the tick output follows ext_tick, so all come straight from flops
  always_comb begin
    next_pll_enable      = next_state == RXPTS_PLL || next_state == RXPTS_SIGP ||
                           next_state == RXPTS_BCHK || next_state == RXPTS_RECV;
    next_sig_proc_enable = next_state == RXPTS_SIGP || next_state == RXPTS_BCHK ||
                           next_state == RXPTS_RECV;
    next_data_valid      = next_state == RXPTS_RECV;
    next_ext_clock_tick  = ext_tick;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state           <= RXPTS_IDLE;
      timer           <= '0;
      ivl             <= '0;
      seen_edge       <= 1'b0;
      good            <= '0;
      PLL_ENABLE      <= 1'b0;
      SIG_PROC_ENABLE <= 1'b0;
      DATA_VALID      <= 1'b0;
      EXT_CLOCK_TICK  <= 1'b0;
    end else begin
      state           <= next_state;
      timer           <= next_timer;
      ivl             <= next_ivl;
      seen_edge       <= next_seen_edge;
      good            <= next_good;
      PLL_ENABLE      <= next_pll_enable;
      SIG_PROC_ENABLE <= next_sig_proc_enable;
      DATA_VALID      <= next_data_valid;
      EXT_CLOCK_TICK  <= next_ext_clock_tick;
    end
  end

endmodule
`default_nettype wire

// file: test/rxpts_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// port-level timing relations of the polling sequencer
module rxpts_monitor
  import rxpts_pkg::*;
(
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RESETN,
  // avalon slave
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // receive path
  input wire logic        RX_DATA,
  input wire logic        PLL_ENABLE,
  input wire logic        SIG_PROC_ENABLE,
  input wire logic        DATA_VALID,
  input wire logic        EXT_CLOCK_TICK
);
  logic [15:0] pll_cnt;
  logic [15:0] next_pll_cnt;
  logic [15:0] sp_cnt;
  logic [15:0] next_sp_cnt;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles spent in the pll phase and from signal start-up to data valid, each cleared as soon as its span ends
  always_comb begin
    next_pll_cnt = (PLL_ENABLE && !SIG_PROC_ENABLE) ? pll_cnt + 16'h1 : 16'h0;
    next_sp_cnt  = (SIG_PROC_ENABLE && !DATA_VALID) ? sp_cnt + 16'h1 : 16'h0;
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pll_cnt <= 16'h0;
      sp_cnt  <= 16'h0;
    end else begin
      pll_cnt <= next_pll_cnt;
      sp_cnt  <= next_sp_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer and phase checks; the pll span allows a basic tick and a half either way, the start-up minimum one basic tick below
  chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    && $past(AVS_WAITREQUEST) |=> !AVS_WAITREQUEST) else $error("request not answered");
  chk_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_wait_cause: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  chk_hole_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  chk_tick_gap: assert property (EXT_CLOCK_TICK |=> !EXT_CLOCK_TICK [*8])
    else $error("extended tick too close");
  chk_pll_span: assert property ($rose(SIG_PROC_ENABLE) |->
    pll_cnt >= 16'h31d0 && pll_cnt <= 16'h3200) else $error("pll start-up length wrong");
  chk_sigp_min: assert property ($rose(DATA_VALID) |-> sp_cnt >= 16'h1010)
    else $error("start-up or bit-check too short");
  chk_sigp_order: assert property (SIG_PROC_ENABLE |-> PLL_ENABLE)
    else $error("signal processing without pll");
  chk_valid_order: assert property (DATA_VALID |-> SIG_PROC_ENABLE)
    else $error("data valid outside receive");
endmodule
bind rxpts_top rxpts_monitor rxpts_monitor_inst (.CLOCK, .RESETN, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .RX_DATA, .PLL_ENABLE,
  .SIG_PROC_ENABLE, .DATA_VALID, .EXT_CLOCK_TICK);
`default_nettype wire

// file: test/rxpts_rx_partner.sv
`timescale 1ns/100ps
`default_nettype none
// remote transmitter: manchester edges every half cycles while enabled
module rxpts_rx_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // pattern control
  input  wire logic        en,
  input  wire logic [15:0] half,
  // demodulated line
  output logic             data
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_data;
  // edge spacing sets t_ee; with no carrier the line holds, giving no edges
  always_comb begin
    next_cnt  = en ? cnt + 16'h1 : 16'h0;
    next_data = data;
    if (en && cnt >= half - 16'h1) begin
      next_cnt  = 16'h0;
      next_data = ~data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 16'h0;
      data <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      data <= next_data;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_rxpts_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rxpts_top;
  import rxpts_pkg::*;
  logic        clock;
  logic        resetn;
  logic        rd;
  logic        wr;
  logic        rx_en;
  logic        rx;
  logic        waitreq;
  logic        pll;
  logic        sigp;
  logic        valid;
  logic        tick;
  logic [3:0]  addr;
  logic [15:0] half;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] q;
  time         t0;
  int          fails;
  int          num_checks;
  wire logic [3:0] outs = {valid, sigp, pll, tick};
  logic [3:0]  ra [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h6};
  logic [31:0] rv [5] = '{32'h0, 32'h0000_0101, 32'h0000_0f05, 32'h0, 32'h0};
  rxpts_top rxpts_top_inst (.CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RX_DATA(rx), .PLL_ENABLE(pll), .SIG_PROC_ENABLE(sigp),
    .DATA_VALID(valid), .EXT_CLOCK_TICK(tick));
  rxpts_rx_partner rxpts_rx_partner_inst (.clk(clock), .rst_n(resetn), .en(rx_en),
    .half(half), .data(rx));
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz crystal clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic int el();
    return int'(($time - t0) / 100);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // elapsed cycles inside a window; the low bound is shown when outside
  task automatic rng(input string nm, input int lo, input int hi);
    int g;
    g = el();
    chk(nm, 32'(g), (g >= lo && g <= hi) ? 32'(g) : 32'(lo));
  endtask
  // one avalon access, held until waitrequest is seen low
  // no cycle count is assumed here: only the watchdog ends a hung access
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clock);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wt(input int i, input logic v);
    int k;
    k = 0;
    while (outs[i] !== v && k < 40000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 40000) fails++;
  endtask
  // poll the status word until the sequencer reports the given state
  task automatic pst(input logic [2:0] s);
    int k;
    k = 0;
    do begin
      acc(1'b0, RXPTS_STATUS_ADDR, 32'h0);
      k++;
    end while (q[2:0] !== s && k < 9000);
    if (k >= 9000) fails++;
  endtask
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog, well beyond the roughly 72k cycles of the sequence
  initial begin
    repeat (95000) @(posedge clock);
    fails++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {rd, wr, rx_en, addr, wdata} = '0;
    half = 16'h00a0;
    fails = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    foreach (ra[i]) begin
      acc(1'b0, ra[i], 32'h0);
      chk("reset_read", q, rv[i]);
    end
    acc(1'b1, RXPTS_SLEEP_ADDR, 32'hffff_ffff);
    acc(1'b1, 4'h6, 32'hffff_ffff);
    acc(1'b0, RXPTS_SLEEP_ADDR, 32'h0);
    chk("sleep_fields", q, 32'h0000_ff1f);
    acc(1'b0, 4'h6, 32'h0);
    chk("hole", q, 32'h0);
    // extended tick for all limit and range codes; long sleep keeps the state still
    acc(1'b1, RXPTS_SLEEP_ADDR, 32'h0000_0101);
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, RXPTS_CTRL_ADDR, 32'({k[1:0], k[2], 1'b1}));
      wt(0, 1'b1);
      wt(0, 1'b0);
      wt(0, 1'b1);
      t0 = $time;
      wt(0, 1'b0);
      wt(0, 1'b1);
      chk("ext_tick", 32'(el()), 32'(16 * ((k[2] ? 16 : 8) >> k[1:0])));
    end
    acc(1'b1, RXPTS_CTRL_ADDR, 32'h0);
    chk("idle_outs", 32'(outs[3:1]), 32'h0);
    // full pass at range 3 with three check periods and a clean signal
    acc(1'b1, RXPTS_CTRL_ADDR, 32'h0000_001d);
    t0 = $time;
    wt(1, 1'b1);
    rng("sleep", 16360, 16408);
    t0 = $time;
    wt(2, 1'b1);
    rng("pll", 12752, 12800);
    rx_en <= 1'b1;
    t0 = $time;
    pst(3'h6);
    rng("sig_proc", 4104, 4160);
    t0 = $time;
    wt(3, 1'b1);
    rng("bchk_pass", 950, 1140);
    acc(1'b0, RXPTS_STATUS_ADDR, 32'h0);
    chk("recv", 32'(q[3:0]), 32'h0000_000f);
    // no carrier, zero sleep: the check gives up within one signal period
    acc(1'b1, RXPTS_CTRL_ADDR, 32'h0);
    // outputs drop at the same edge that takes the state out of receive
    @(posedge clock);
    chk("recv_drop", 32'(outs[3:1]), 32'h0);
    rx_en <= 1'b0;
    acc(1'b1, RXPTS_SLEEP_ADDR, 32'h0);
    acc(1'b1, RXPTS_CTRL_ADDR, 32'h0000_001d);
    pst(3'h6);
    t0 = $time;
    wt(1, 1'b0);
    rng("bchk_quiet", 0, 330);
    acc(1'b0, RXPTS_STATUS_ADDR, 32'h0);
    chk("fail_flag", 32'(q[16]), 32'h1);
    // edges far closer than the lower limit fail as well
    half <= 16'h0020;
    rx_en <= 1'b1;
    pst(3'h6);
    t0 = $time;
    wt(1, 1'b0);
    rng("bchk_short", 0, 330);
    acc(1'b1, RXPTS_CTRL_ADDR, 32'h0);
    acc(1'b1, RXPTS_STATUS_ADDR, 32'h0001_0000);
    acc(1'b0, RXPTS_STATUS_ADDR, 32'h0);
    chk("fail_clear", 32'(q[16]), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
